// ===== scgbd_defs.vh
// Constants for the sleep clock gate and backup domain control block.
// Assumes inclusion by bare name from the design files of this block.
`ifndef SCGBD_DEFS_VH
`define SCGBD_DEFS_VH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define SCGBD_OFS_SLEEP_GATES 8'h64
`define SCGBD_OFS_BD_CTRL 8'h70
`define SCGBD_ADDR_W 8

// ----------------------------------------------------------------
// Reset values and writable masks
// ----------------------------------------------------------------
`define SCGBD_SLEEP_RESET 32'h00077930
`define SCGBD_SLEEP_MASK 32'h00177B33
`define SCGBD_BD_RESET 32'h00000000
`define SCGBD_ZERO 32'h00000000

// ----------------------------------------------------------------
// Sleep gate bit positions
// ----------------------------------------------------------------
`define SCGBD_B_ADV_TMR_A 0
`define SCGBD_B_ADV_TMR_B 1
`define SCGBD_B_SER_A 4
`define SCGBD_B_SER_B 5
`define SCGBD_B_CONV_A 8
`define SCGBD_B_CONV_B 9
`define SCGBD_B_CARD 11
`define SCGBD_B_SPI_A 12
`define SCGBD_B_SPI_B 13
`define SCGBD_B_SYSCFG 14
`define SCGBD_B_GP_TMR_A 16
`define SCGBD_B_GP_TMR_B 17
`define SCGBD_B_GP_TMR_C 18
`define SCGBD_B_SPI_C 20

// ----------------------------------------------------------------
// Backup domain control fields
// ----------------------------------------------------------------
`define SCGBD_B_LSE_EN 0
`define SCGBD_B_LSE_RDY 1
`define SCGBD_B_LSE_BYP 2
`define SCGBD_F_RTC_SEL_HI 9
`define SCGBD_F_RTC_SEL_LO 8
`define SCGBD_B_RTC_GATE 15
`define SCGBD_B_BD_SRST 16

// ----------------------------------------------------------------
// Clock source codes and prescaler
// ----------------------------------------------------------------
`define SCGBD_SRC_NONE 2'h0
`define SCGBD_SRC_LSE 2'h1
`define SCGBD_SRC_LSI 2'h2
`define SCGBD_SRC_HSE 2'h3
`define SCGBD_PSC_W 5
`define SCGBD_PSC_MIN 5'h02
`define SCGBD_PSC_ONE 5'h01
`define SCGBD_PSC_ZERO 5'h00

`endif

// ===== scgbd_rtc_clk.v
// Real-time clock source mux, high-speed divider and output gate.
// Assumes the source clocks are slow against clock and already synchronous.
`timescale 1ns/100ps

`include "scgbd_defs.vh"

module scgbd_rtc_clk (
  input wire clock, // System clock
  input wire bd_rst, // Backup-domain reset, async, high
  input wire hold, // Backup-domain soft reset level
  input wire [1:0] sel, // Clock source select
  input wire gate, // Pass selected clock when high
  input wire lse_clk, // Low-speed external clock level
  input wire lsi_clk, // Low-speed internal clock level
  input wire hse_clk, // High-speed external clock level
  input wire [4:0] psc, // High-speed divide factor
  output reg rtc_clk_q // Gated real-time clock
);

  reg hse_prev_q;
  reg [4:0] div_cnt_q;
  reg div_clk_q;
  reg sel_clk;

  // ----------------------------------------------------------------
  // High-speed divider
  // ----------------------------------------------------------------
  // Factors below two give no clock rather than a degenerate one
  always @(posedge clock or posedge bd_rst) begin
    if (bd_rst) begin
      hse_prev_q <= 1'b0;
      div_cnt_q <= `SCGBD_PSC_ZERO;
      div_clk_q <= 1'b0;
    end else if (hold || psc < `SCGBD_PSC_MIN) begin
      hse_prev_q <= hse_clk;
      div_cnt_q <= `SCGBD_PSC_ZERO;
      div_clk_q <= 1'b0;
    end else begin
      hse_prev_q <= hse_clk;
      if (hse_clk && !hse_prev_q) begin
        if (div_cnt_q >= psc - `SCGBD_PSC_ONE) begin
          div_cnt_q <= `SCGBD_PSC_ZERO;
        end else begin
          div_cnt_q <= div_cnt_q + `SCGBD_PSC_ONE;
        end
        div_clk_q <= (div_cnt_q >= psc - `SCGBD_PSC_ONE) ||
                     (div_cnt_q + `SCGBD_PSC_ONE < (psc >> 1));
      end
    end
  end

  // ----------------------------------------------------------------
  // Source mux and gate
  // ----------------------------------------------------------------
  always @* begin
    case (sel)
      `SCGBD_SRC_LSE: sel_clk = lse_clk;
      `SCGBD_SRC_LSI: sel_clk = lsi_clk;
      `SCGBD_SRC_HSE: sel_clk = div_clk_q;
      default: sel_clk = 1'b0;
    endcase
  end

  always @(posedge clock or posedge bd_rst) begin
    if (bd_rst) begin
      rtc_clk_q <= 1'b0;
    end else begin
      rtc_clk_q <= sel_clk && gate && !hold;
    end
  end

endmodule // scgbd_rtc_clk

// ===== scgbd_top.v
// Sleep-mode clock gates for peripheral bus 2 and backup domain control.
// Assumes a simple strobe bus on clock and a separate backup-domain reset.
`timescale 1ns/100ps

`include "scgbd_defs.vh"

module scgbd_top (
  input wire clock, // System clock, 125 MHz
  input wire rst, // System reset, async, high
  input wire bd_rst, // Backup-domain reset, async, high
  input wire [7:0] bus_addr, // Byte address
  input wire [31:0] bus_wdata, // Write data
  input wire [3:0] bus_be, // Byte enables for write
  input wire bus_wr, // Write strobe
  input wire bus_rd, // Read strobe
  output reg [31:0] bus_rdata_q, // Read data, cycle after read strobe
  input wire sleep_mode, // Core is in sleep mode
  input wire backup_write_unlock, // Unlock bit from power_control_reg
  input wire [4:0] rtc_hse_prescaler, // Divide factor from clock_config_reg
  input wire lse_stable, // Oscillator reports stable clock
  input wire low_speed_ext_clock, // Low-speed external clock level
  input wire low_speed_int_clock, // Low-speed internal clock level
  input wire high_speed_ext_clock, // High-speed external clock level
  output wire adv_timer_a_clk_run, // Clock enable, advanced timer A
  output wire adv_timer_b_clk_run, // Clock enable, advanced timer B
  output wire serial_port_a_clk_run, // Clock enable, serial port A
  output wire serial_port_b_clk_run, // Clock enable, serial port B
  output wire converter_a_clk_run, // Clock enable, converter A interface
  output wire converter_b_clk_run, // Clock enable, converter B interface
  output wire card_if_clk_run, // Clock enable, card interface
  output wire spi_port_a_clk_run, // Clock enable, SPI port A
  output wire spi_port_b_clk_run, // Clock enable, SPI port B
  output wire spi_port_c_clk_run, // Clock enable, SPI port C
  output wire sys_config_clk_run, // Clock enable, system config unit
  output wire gp_timer_a_clk_run, // Clock enable, timer A
  output wire gp_timer_b_clk_run, // Clock enable, timer B
  output wire gp_timer_c_clk_run, // Clock enable, timer C
  output wire lse_osc_on, // Oscillator enable out
  output wire lse_bypass_on, // Oscillator bypass out
  output wire backup_domain_in_reset, // Backup domain soft reset level
  output wire rtc_clock // Real-time clock out
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function [31:0] be_merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0] be;
    integer i;
    begin
      be_merge = old_v;
      for (i = 0; i < 4; i = i + 1) begin
        if (be[i]) begin
          be_merge[i*8 +: 8] = new_v[i*8 +: 8];
        end
      end
    end
  endfunction

  function addr_hit;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      addr_hit = (addr[7:2] == ofs[7:2]);
    end
  endfunction

  function run_in_sleep;
    input sleeping;
    input gate;
    begin
      run_in_sleep = !sleeping || gate;
    end
  endfunction

  // Reserved positions stay zero whatever the fields hold
  function [31:0] bd_pack;
    input osc_en;
    input ready;
    input bypass;
    input [1:0] source;
    input clk_gate;
    input soft_rst;
    begin
      bd_pack = `SCGBD_ZERO;
      bd_pack[`SCGBD_B_LSE_EN] = osc_en;
      bd_pack[`SCGBD_B_LSE_RDY] = ready;
      bd_pack[`SCGBD_B_LSE_BYP] = bypass;
      bd_pack[`SCGBD_F_RTC_SEL_HI:`SCGBD_F_RTC_SEL_LO] = source;
      bd_pack[`SCGBD_B_RTC_GATE] = clk_gate;
      bd_pack[`SCGBD_B_BD_SRST] = soft_rst;
    end
  endfunction

  // ----------------------------------------------------------------
  // Sleep gate register
  // ----------------------------------------------------------------
  reg [31:0] sleep_gates_q;
  wire sleep_hit = addr_hit(bus_addr, `SCGBD_OFS_SLEEP_GATES);
  wire bd_hit = addr_hit(bus_addr, `SCGBD_OFS_BD_CTRL);
  wire sleep_wr = bus_wr && sleep_hit;
  wire sleep_rd = bus_rd && sleep_hit;
  wire bd_rd = bus_rd && bd_hit;
  wire [31:0] sleep_d = be_merge(sleep_gates_q, bus_wdata, bus_be) & `SCGBD_SLEEP_MASK;

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      sleep_gates_q <= `SCGBD_SLEEP_RESET;
    end else if (sleep_wr) begin
      sleep_gates_q <= sleep_d;
    end
  end

  // ----------------------------------------------------------------
  // Sleep gate fields
  // ----------------------------------------------------------------
  wire adv_timer_a_sleep_gate = sleep_gates_q[`SCGBD_B_ADV_TMR_A];
  wire adv_timer_b_sleep_gate = sleep_gates_q[`SCGBD_B_ADV_TMR_B];
  wire serial_port_a_sleep_gate = sleep_gates_q[`SCGBD_B_SER_A];
  wire serial_port_b_sleep_gate = sleep_gates_q[`SCGBD_B_SER_B];
  wire converter_a_sleep_gate = sleep_gates_q[`SCGBD_B_CONV_A];
  wire converter_b_sleep_gate = sleep_gates_q[`SCGBD_B_CONV_B];
  wire card_if_sleep_gate = sleep_gates_q[`SCGBD_B_CARD];
  wire spi_port_a_sleep_gate = sleep_gates_q[`SCGBD_B_SPI_A];
  wire spi_port_b_sleep_gate = sleep_gates_q[`SCGBD_B_SPI_B];
  wire spi_port_c_sleep_gate = sleep_gates_q[`SCGBD_B_SPI_C];
  wire sys_config_sleep_gate = sleep_gates_q[`SCGBD_B_SYSCFG];
  wire gp_timer_a_sleep_gate = sleep_gates_q[`SCGBD_B_GP_TMR_A];
  wire gp_timer_b_sleep_gate = sleep_gates_q[`SCGBD_B_GP_TMR_B];
  wire gp_timer_c_sleep_gate = sleep_gates_q[`SCGBD_B_GP_TMR_C];

  // ----------------------------------------------------------------
  // Clock enables out
  // ----------------------------------------------------------------
  // Clock runs outside sleep, and in sleep only where the gate bit is set
  assign adv_timer_a_clk_run = run_in_sleep(sleep_mode, adv_timer_a_sleep_gate);
  assign adv_timer_b_clk_run = run_in_sleep(sleep_mode, adv_timer_b_sleep_gate);
  assign serial_port_a_clk_run = run_in_sleep(sleep_mode, serial_port_a_sleep_gate);
  assign serial_port_b_clk_run = run_in_sleep(sleep_mode, serial_port_b_sleep_gate);
  assign converter_a_clk_run = run_in_sleep(sleep_mode, converter_a_sleep_gate);
  assign converter_b_clk_run = run_in_sleep(sleep_mode, converter_b_sleep_gate);
  assign card_if_clk_run = run_in_sleep(sleep_mode, card_if_sleep_gate);
  assign spi_port_a_clk_run = run_in_sleep(sleep_mode, spi_port_a_sleep_gate);
  assign spi_port_b_clk_run = run_in_sleep(sleep_mode, spi_port_b_sleep_gate);
  assign spi_port_c_clk_run = run_in_sleep(sleep_mode, spi_port_c_sleep_gate);
  assign sys_config_clk_run = run_in_sleep(sleep_mode, sys_config_sleep_gate);
  assign gp_timer_a_clk_run = run_in_sleep(sleep_mode, gp_timer_a_sleep_gate);
  assign gp_timer_b_clk_run = run_in_sleep(sleep_mode, gp_timer_b_sleep_gate);
  assign gp_timer_c_clk_run = run_in_sleep(sleep_mode, gp_timer_c_sleep_gate);

  // ----------------------------------------------------------------
  // Backup domain control
  // ----------------------------------------------------------------
  // Reset by the backup-domain reset and held clear by the soft reset bit; system reset leaves it alone
  reg lse_en_q;
  reg lse_byp_q;
  reg [1:0] rtc_sel_q;
  reg rtc_gate_q;
  reg bd_srst_q;
  reg lse_rdy_q;

  reg lse_en_d;
  reg lse_byp_d;
  reg [1:0] rtc_sel_d;
  reg rtc_gate_d;
  reg bd_srst_d;

  // ----------------------------------------------------------------
  // Backup domain fields
  // ----------------------------------------------------------------
  wire low_speed_ext_osc_enable = lse_en_q;
  wire low_speed_ext_ready = lse_rdy_q;
  wire low_speed_ext_bypass = lse_byp_q;
  wire [1:0] rtc_source_select = rtc_sel_q;
  wire rtc_clock_gate = rtc_gate_q;
  wire backup_domain_soft_reset = bd_srst_q;

  wire [31:0] bd_cur = bd_pack(low_speed_ext_osc_enable, low_speed_ext_ready,
                               low_speed_ext_bypass, rtc_source_select,
                               rtc_clock_gate, backup_domain_soft_reset);
  wire [31:0] bd_new = be_merge(bd_cur, bus_wdata, bus_be);
  wire bd_wr = bus_wr && bd_hit;
  // Field writes other than the soft reset bit need the power-unit unlock and a released soft reset
  wire bd_fields_open = backup_write_unlock && !backup_domain_soft_reset;
  wire rtc_sel_free = (rtc_source_select == `SCGBD_SRC_NONE);
  // Ready only while the oscillator is on and reports stable
  wire lse_rdy_d = lse_stable && lse_en_q && !bd_srst_q;

  always @* begin
    lse_en_d = lse_en_q;
    lse_byp_d = lse_byp_q;
    rtc_sel_d = rtc_sel_q;
    rtc_gate_d = rtc_gate_q;
    bd_srst_d = bd_srst_q;
    if (bd_wr) begin
      bd_srst_d = bd_new[`SCGBD_B_BD_SRST];
      if (bd_fields_open) begin
        lse_en_d = bd_new[`SCGBD_B_LSE_EN];
        lse_byp_d = bd_new[`SCGBD_B_LSE_BYP];
        rtc_gate_d = bd_new[`SCGBD_B_RTC_GATE];
        // Source is locked once chosen; only a domain reset frees it
        if (rtc_sel_free) begin
          rtc_sel_d = bd_new[`SCGBD_F_RTC_SEL_HI:`SCGBD_F_RTC_SEL_LO];
        end
      end
    end
    if (bd_srst_d) begin
      lse_en_d = 1'b0;
      lse_byp_d = 1'b0;
      rtc_sel_d = `SCGBD_SRC_NONE;
      rtc_gate_d = 1'b0;
    end
  end

  always @(posedge clock or posedge bd_rst) begin
    if (bd_rst) begin
      lse_en_q <= 1'b0;
      lse_byp_q <= 1'b0;
      rtc_sel_q <= `SCGBD_SRC_NONE;
      rtc_gate_q <= 1'b0;
      bd_srst_q <= 1'b0;
    end else begin
      lse_en_q <= lse_en_d;
      lse_byp_q <= lse_byp_d;
      rtc_sel_q <= rtc_sel_d;
      rtc_gate_q <= rtc_gate_d;
      bd_srst_q <= bd_srst_d;
    end
  end

  // Pure hardware flag: software writes never reach it
  always @(posedge clock or posedge bd_rst) begin
    if (bd_rst) begin
      lse_rdy_q <= 1'b0;
    end else begin
      lse_rdy_q <= lse_rdy_d;
    end
  end

  assign lse_osc_on = low_speed_ext_osc_enable;
  assign lse_bypass_on = low_speed_ext_bypass;
  assign backup_domain_in_reset = backup_domain_soft_reset;

  // ----------------------------------------------------------------
  // Real-time clock generation
  // ----------------------------------------------------------------
  scgbd_rtc_clk u_rtc_clk (
    .clock(clock),
    .bd_rst(bd_rst),
    .hold(bd_srst_q),
    .sel(rtc_sel_q),
    .gate(rtc_gate_q),
    .lse_clk(low_speed_ext_clock),
    .lsi_clk(low_speed_int_clock),
    .hse_clk(high_speed_ext_clock),
    .psc(rtc_hse_prescaler),
    .rtc_clk_q(rtc_clock)
  );

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Answers in one cycle for both registers: zero waits lies in the
  // permitted range and the bus cannot stall
  reg [31:0] rdata_d;

  always @* begin
    rdata_d = `SCGBD_ZERO;
    if (sleep_rd) begin
      rdata_d = sleep_gates_q;
    end else if (bd_rd) begin
      rdata_d = bd_cur;
    end
  end

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      bus_rdata_q <= `SCGBD_ZERO;
    end else begin
      bus_rdata_q <= rdata_d;
    end
  end

endmodule // scgbd_top

// ===== scgbd_sva.sv
// Checker for the sleep clock gate and backup domain block, top-level ports only.
// Assumes one clock domain; the backup reset acts as a second async reset.
`timescale 1ns/100ps

module scgbd_sva (
  input logic clock, // System clock
  input logic rst, // System reset
  input logic bd_rst, // Backup-domain reset
  input logic [7:0] bus_addr, // Byte address
  input logic [31:0] bus_wdata, // Write data
  input logic [3:0] bus_be, // Byte enables
  input logic bus_wr, // Write strobe
  input logic bus_rd, // Read strobe
  input logic [31:0] bus_rdata_q, // Read data
  input logic sleep_mode, // Core sleeping
  input logic backup_write_unlock, // Unlock level
  input logic adv_timer_a_clk_run, // Lowest gate
  input logic spi_port_c_clk_run, // Highest gate
  input logic lse_osc_on, // Oscillator enable
  input logic lse_bypass_on, // Bypass
  input logic backup_domain_in_reset, // Soft reset level
  input logic rtc_clock // Real-time clock
);
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  wire bd_wr = bus_wr && bus_addr[7:2] == 6'h1C;
  wire srst_wr = bd_wr && bus_be[2] && bus_wdata[16];

  chk_rdata_idle: assert property (@(posedge clock) disable iff (rst)
    !$past(bus_rd) |-> bus_rdata_q == 32'h0) else $error("read data not zero when idle");
  chk_gate_awake: assert property (@(posedge clock) disable iff (rst)
    !sleep_mode |-> adv_timer_a_clk_run && spi_port_c_clk_run) else $error("clock off while awake");
  chk_gate_follow: assert property (@(posedge clock) disable iff (rst)
    sleep_mode && bus_wr && bus_addr[7:2] == 6'h19 && bus_be[0] |=>
    adv_timer_a_clk_run == ($past(bus_wdata[0]) || !sleep_mode)) else $error("gate bit 0 wrong");
  chk_lock_hold: assert property (@(posedge clock) disable iff (bd_rst)
    bd_wr && !backup_write_unlock && !srst_wr |=> $stable(lse_osc_on) && $stable(lse_bypass_on))
    else $error("locked write changed backup bits");
  chk_srst_clear: assert property (@(posedge clock) disable iff (bd_rst)
    srst_wr |=> backup_domain_in_reset && !lse_osc_on && !lse_bypass_on)
    else $error("soft reset did not clear");
  chk_srst_hold: assert property (@(posedge clock) disable iff (bd_rst)
    backup_domain_in_reset |=> !rtc_clock && !lse_osc_on) else $error("active during soft reset");
  chk_bd_clear: assert property (@(posedge clock) disable iff (rst)
    bd_rst |-> !lse_osc_on && !lse_bypass_on && !backup_domain_in_reset && !rtc_clock)
    else $error("backup reset did not clear");
  chk_sys_keep: assert property (@(posedge clock) disable iff (bd_rst)
    rst |=> $stable(lse_osc_on) && $stable(lse_bypass_on)) else $error("system reset hit backup");

  cov_srst: cover property (@(posedge clock) srst_wr);
  cov_locked: cover property (@(posedge clock) bd_wr && !backup_write_unlock);
  cov_sleep_wr: cover property (@(posedge clock) sleep_mode && bus_wr);
endmodule // scgbd_sva

bind scgbd_top scgbd_sva scgbd_sva_u (.*);

// ===== testbench.sv
// Self-checking bench for the sleep clock gate and backup domain block.
// Assumes the design files and the checker file are compiled before it.
`timescale 1ns/100ps

module testbench;
  localparam logic [31:0] MAP = 32'h00177B33;
  logic clock = 1'h0, rst = 1'h1, bd_rst = 1'h1;
  logic [7:0] bus_addr = 8'h00;
  logic [31:0] bus_wdata = 32'h0;
  logic [3:0] bus_be = 4'hF;
  logic bus_wr = 1'h0, bus_rd = 1'h0, sleep_mode = 1'h0, backup_write_unlock = 1'h0;
  logic lse_stable = 1'h0, low_speed_ext_clock = 1'h0, low_speed_int_clock = 1'h0;
  logic high_speed_ext_clock = 1'h0;
  logic [4:0] rtc_hse_prescaler = 5'h04;
  wire [31:0] bus_rdata_q;
  wire adv_timer_a_clk_run, adv_timer_b_clk_run, serial_port_a_clk_run, serial_port_b_clk_run;
  wire converter_a_clk_run, converter_b_clk_run, card_if_clk_run, spi_port_a_clk_run;
  wire spi_port_b_clk_run, spi_port_c_clk_run, sys_config_clk_run, gp_timer_a_clk_run;
  wire gp_timer_b_clk_run, gp_timer_c_clk_run;
  wire lse_osc_on, lse_bypass_on, backup_domain_in_reset, rtc_clock;
  wire [31:0] run_v = {11'h0, spi_port_c_clk_run, 1'h0, gp_timer_c_clk_run, gp_timer_b_clk_run,
    gp_timer_a_clk_run, 1'h0, sys_config_clk_run, spi_port_b_clk_run, spi_port_a_clk_run,
    card_if_clk_run, 1'h0, converter_b_clk_run, converter_a_clk_run, 2'h0,
    serial_port_b_clk_run, serial_port_a_clk_run, 2'h0, adv_timer_b_clk_run, adv_timer_a_clk_run};
  int err_count = 0, tests_run = 0, rises = 0, i;

  scgbd_top dut_u (.*);

  always #4 clock = ~clock;
  always @(posedge rtc_clock) rises++;

  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  // Strobe left high so a following transfer can go back to back
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge clock);
    bus_wr <= 1'h1;
    bus_rd <= 1'h0;
    bus_addr <= a;
    bus_wdata <= d;
    bus_be <= be;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock);
    bus_rd <= 1'h1;
    bus_wr <= 1'h0;
    bus_addr <= a;
    @(posedge clock);
    bus_rd <= 1'h0;
    #1;
    check(bus_rdata_q, exp);
  endtask

  task automatic nop;
    @(posedge clock);
    bus_wr <= 1'h0;
    bus_rd <= 1'h0;
    #1;
  endtask

  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clock);
    rst <= 1'h0;
    bd_rst <= 1'h0;
    rd(8'h64, 32'h00077930);
    rd(8'h70, 32'h0);
    rd(8'h68, 32'h0);
    wr(8'h64, 32'hFFFFFFFF, 4'hF);
    rd(8'h64, MAP);
    sleep_mode <= 1'h1;
    for (i = 0; i < 32; i++) begin
      if (MAP[i]) begin
        wr(8'h64, 32'h1 << i, 4'hF);
        nop;
        check(run_v, 32'h1 << i);
      end
    end
    sleep_mode <= 1'h0;
    nop;
    check(run_v, MAP);
    wr(8'h64, 32'h0, 4'hF);
    wr(8'h64, 32'hFFFFFFFF, 4'h2);
    rd(8'h64, 32'h00007B00);
    wr(8'h70, 32'h00008305, 4'hF);
    rd(8'h70, 32'h0);
    backup_write_unlock <= 1'h1;
    wr(8'h70, 32'hFFFEFEFF, 4'hF);
    rd(8'h70, 32'h00008205);
    check({30'h0, lse_osc_on, lse_bypass_on}, 32'h3);
    lse_stable <= 1'h1;
    wr(8'h70, 32'h00008105, 4'hF);
    nop;
    rd(8'h70, 32'h00008207);
    lse_stable <= 1'h0;
    nop;
    nop;
    rd(8'h70, 32'h00008205);
    low_speed_int_clock <= 1'h1;
    repeat (3) nop;
    check({31'h0, rtc_clock}, 32'h1);
    low_speed_int_clock <= 1'h0;
    repeat (3) nop;
    check({31'h0, rtc_clock}, 32'h0);
    wr(8'h70, 32'h00000205, 4'hF);
    low_speed_int_clock <= 1'h1;
    repeat (3) nop;
    check({31'h0, rtc_clock}, 32'h0);
    rst <= 1'h1;
    nop;
    rst <= 1'h0;
    rd(8'h70, 32'h00000205);
    rd(8'h64, 32'h00077930);
    wr(8'h70, 32'h00010000, 4'hF);
    nop;
    check({31'h0, backup_domain_in_reset}, 32'h1);
    rd(8'h70, 32'h00010000);
    wr(8'h70, 32'h0, 4'hF);
    rd(8'h70, 32'h0);
    wr(8'h70, 32'h00008000, 4'hF);
    repeat (3) nop;
    check({31'h0, rtc_clock}, 32'h0);
    wr(8'h70, 32'h00008300, 4'hF);
    nop;
    rises = 0;
    // Divider of 4 on a 4-cycle source gives one rise per 16 cycles
    for (i = 0; i < 160; i++) begin
      @(posedge clock);
      if (i % 2 == 0) high_speed_ext_clock <= ~high_speed_ext_clock;
    end
    check({31'h0, rises >= 9 && rises <= 11}, 32'h1);
    bd_rst <= 1'h1;
    nop;
    bd_rst <= 1'h0;
    rd(8'h70, 32'h0);
    wr(8'h70, 32'h00008101, 4'hF);
    low_speed_ext_clock <= 1'h1;
    repeat (3) nop;
    check({31'h0, rtc_clock}, 32'h1);
    low_speed_ext_clock <= 1'h0;
    repeat (3) nop;
    check({31'h0, rtc_clock}, 32'h0);
    print_verdict;
  end

  initial begin
    repeat (20000) @(posedge clock);
    err_count++;
    print_verdict;
  end
endmodule // testbench
